// ===== hdl/fmb_backplane_ctrl.sv
// Functional notes
// - ID read: id low byte, upper byte ones
// - ID: component field high, terminal type low
// - No terminal module: type bits all ones
// - Status register 2: bits 0-11 defined
// - Status bits 8-11: tree 91-94, one=closed
// - Bank B bits 7-4, A 3-0, F=open
// - Reset write opens all, stops coordination
// - Register 3 write: opening strobe, open selected
// - Register 4 write: open relays, opening strobe
// - Register 5: close relays after opening ends
// - Relay closing pulses closing line
// - Register 6 write: closing strobe, close selected
// - Command word mask and data layout
// - Bit 15 closes isolation relays (ch 90)
// - Only masked groups act; masks combine
// - Tree bits 11..8 map channels 94..91
// - Bank nibble is decimal; B a decade up
// - Register number picks open or close
// - Relays stay closed until open or reset
`timescale 1ns/10ps
`include "fmb_params.svh"
module fmb_backplane_ctrl #(
   parameter logic [4:0] COMPONENT_ID = 5'h15, // Arbitrary value
   parameter int STROBE_CYC = `FMB_STROBE_CYC
) (
   // Clock, reset, enable
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   // Backplane register access
   input wire logic [2:0] bp_addr,
   input wire logic bp_rd_stb,
   input wire logic bp_wr_stb,
   input wire logic [15:0] bp_wdata,
   output logic [15:0] bp_rdata,
   output logic bp_rdata_vld,
   // Backplane coordination
   input wire logic bp_sys_reset,
   input wire logic bp_opening_in,
   output logic bp_opening_pulse,
   output logic bp_closing_pulse,
   // Terminal module sense
   input wire logic term_present,
   input wire logic [2:0] term_type,
   // Switch drive
   output logic relay_closed,
   output logic [3:0] tree_closed,
   output logic [9:0] bank_a_closed,
   output logic [9:0] bank_b_closed
);
   import fmb_pkg::*;

   // Parameter range check
   if (STROBE_CYC < 1 || STROBE_CYC > 255) begin : g_bad_strobe
      $error("STROBE_CYC must lie in 1..255");
   end

   fmb_sw_if sw ();
   fmb_state_t fsm_reg;
   fmb_state_t fsm_next;
   logic [7:0] cnt_reg;
   logic [15:0] cmd_reg;
   logic pend_relay_reg;
   logic pend_cmd_reg;
   logic clear_now;
   logic wr_ok;
   logic wr_open;
   logic wr_rly_open;
   logic wr_rly_close;
   logic wr_close;
   logic do_close;
   logic cnt_done;
   logic [7:0] ident;
   logic [15:0] stat_word;
   logic [15:0] acc_word;

   fmb_switch_bank u_bank (
      .core_clk(core_clk),
      .rst(rst),
      .sw(sw.bank)
   );

   // Write decode; only the idle sequencer takes open and close writes, reset writes act in any state
   assign clear_now = bp_sys_reset || (bp_wr_stb && bp_addr == `FMB_REG_RESET);
   assign wr_ok = bp_wr_stb && !clear_now && fsm_reg == FMB_ST_IDLE;
   assign wr_open = wr_ok && bp_addr == `FMB_REG_OPEN;
   assign wr_rly_open = wr_ok && bp_addr == `FMB_REG_RLY_OPEN;
   assign wr_rly_close = wr_ok && bp_addr == `FMB_REG_RLY_CLOSE;
   assign wr_close = wr_ok && bp_addr == `FMB_REG_CLOSE;
   assign do_close = fsm_reg == FMB_ST_WAIT && !bp_opening_in;
   assign cnt_done = cnt_reg == 8'h00;

   // Commands to the switch bank
   assign sw.clk_en = clk_en;
   assign sw.clear_all = clear_now;
   assign sw.cmd = wr_open ? bp_wdata : cmd_reg;
   assign sw.apply_open = wr_open;
   assign sw.apply_close = do_close && pend_cmd_reg;
   assign sw.relay_open = wr_rly_open;
   assign sw.relay_close = do_close && (pend_relay_reg || (pend_cmd_reg && cmd_reg[`FMB_MSK_RELAY]));

   // Sequencer next state
   always_comb begin
      fsm_next = fsm_reg;
      case (fsm_reg)
         FMB_ST_IDLE: begin
            if (wr_open || wr_rly_open) begin
               fsm_next = FMB_ST_OPEN;
            end else if (wr_rly_close || wr_close) begin
               fsm_next = FMB_ST_WAIT;
            end
         end
         FMB_ST_OPEN: begin
            if (cnt_done) begin
               fsm_next = FMB_ST_IDLE;
            end
         end
         FMB_ST_WAIT: begin
            if (do_close) begin
               fsm_next = FMB_ST_CLOSE;
            end
         end
         FMB_ST_CLOSE: begin
            if (cnt_done) begin
               fsm_next = FMB_ST_IDLE;
            end
         end
         default: begin
            fsm_next = FMB_ST_IDLE;
         end
      endcase
      if (clear_now) begin
         fsm_next = FMB_ST_IDLE;
      end
   end

   // Sequencer state
   always_ff @(posedge core_clk) begin
      if (rst) begin
         fsm_reg <= FMB_ST_IDLE;
      end else if (clk_en) begin
         fsm_reg <= fsm_next;
      end
   end

   // Strobe width counter
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt_reg <= 8'h00;
      end else if (clk_en) begin
         if (wr_open || wr_rly_open || do_close) begin
            cnt_reg <= 8'(STROBE_CYC - 1);
         end else if (!cnt_done) begin
            cnt_reg <= cnt_reg - 8'h01;
         end
      end
   end

   // Pending close work, held until the opening line drops
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cmd_reg <= 16'h0000;
         pend_relay_reg <= 1'b0;
         pend_cmd_reg <= 1'b0;
      end else if (clk_en) begin
         if (clear_now || do_close) begin
            pend_relay_reg <= 1'b0;
            pend_cmd_reg <= 1'b0;
         end else if (wr_rly_close) begin
            pend_relay_reg <= 1'b1;
         end else if (wr_close) begin
            cmd_reg <= bp_wdata;
            pend_cmd_reg <= 1'b1;
         end
      end
   end

   // Backplane opening and closing strobes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         bp_opening_pulse <= 1'b0;
         bp_closing_pulse <= 1'b0;
      end else if (clk_en) begin
         bp_opening_pulse <= fsm_next == FMB_ST_OPEN;
         bp_closing_pulse <= fsm_next == FMB_ST_CLOSE;
      end
   end

   // Read words
   assign ident = {COMPONENT_ID, term_present ? term_type : `FMB_TERM_NONE};
   assign stat_word = {`FMB_STAT_UNDEF, sw.state.tree, sw.state.bank_b, sw.state.bank_a};
   assign acc_word = {13'h0000, sw.state.relay, fsm_reg == FMB_ST_WAIT, fsm_reg != FMB_ST_IDLE};

   // Register read port, answer one cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (rst) begin
         bp_rdata <= 16'h0000;
         bp_rdata_vld <= 1'b0;
      end else if (clk_en) begin
         bp_rdata_vld <= bp_rd_stb;
         if (bp_rd_stb) begin
            case (bp_addr)
               `FMB_REG_IDENT: bp_rdata <= {`FMB_ID_UPPER, ident};
               `FMB_REG_ACCESS: bp_rdata <= acc_word;
               `FMB_REG_STATUS: bp_rdata <= stat_word;
               default: bp_rdata <= 16'h0000;
            endcase
         end
      end
   end

   // Switch drive outputs
   always_ff @(posedge core_clk) begin
      if (rst) begin
         relay_closed <= 1'b0;
         tree_closed <= 4'h0;
         bank_a_closed <= 10'h000;
         bank_b_closed <= 10'h000;
      end else if (clk_en) begin
         relay_closed <= sw.state.relay;
         tree_closed <= sw.state.tree;
         bank_a_closed <= fmb_onehot10(sw.state.bank_a);
         bank_b_closed <= fmb_onehot10(sw.state.bank_b);
      end
   end

   // Checks
   sequence s_id_read;
      bp_rd_stb && bp_addr == `FMB_REG_IDENT;
   endsequence

   sequence s_close_go;
      fsm_reg == FMB_ST_WAIT && !bp_opening_in && !clear_now;
   endsequence

   a_id_upper: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
      s_id_read |=> bp_rdata[15:8] == 8'hFF && bp_rdata_vld)
      else $error("id upper byte not all ones");

   a_id_component: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
      s_id_read |=> bp_rdata[7:3] == COMPONENT_ID)
      else $error("id component field wrong");

   a_id_no_term: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
      s_id_read ##0 !term_present |=> bp_rdata[2:0] == 3'h7)
      else $error("missing terminal not reported");

   a_status_word: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
      bp_rd_stb && bp_addr == `FMB_REG_STATUS |=> bp_rdata[11:8] == $past(sw.state.tree)
      && bp_rdata[7:4] == $past(sw.state.bank_b) && bp_rdata[3:0] == $past(sw.state.bank_a))
      else $error("status word mismatch");

   a_reset_opens: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
      clear_now |=> !sw.state.relay && sw.state.tree == 4'h0 && sw.state.bank_a == 4'hF
      && sw.state.bank_b == 4'hF && fsm_reg == FMB_ST_IDLE)
      else $error("reset write left a switch closed");

   a_open_strobe: assert property (@(posedge core_clk) disable iff (rst || !clk_en || clear_now)
      wr_open |=> bp_opening_pulse && !bp_closing_pulse)
      else $error("opening strobe missing");

   a_relay_open: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
      wr_rly_open |=> !sw.state.relay && bp_opening_pulse)
      else $error("relay open write failed");

   a_hold_make: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
      fsm_reg == FMB_ST_WAIT && bp_opening_in && !clear_now
      |=> !bp_closing_pulse && sw.state.relay == $past(sw.state.relay))
      else $error("make during opening");

   a_close_strobe: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
      s_close_go |=> bp_closing_pulse && fsm_reg == FMB_ST_CLOSE)
      else $error("closing strobe missing");

   a_tree_close: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
      sw.apply_close && !clear_now && cmd_reg[`FMB_MSK_TREE]
      |=> sw.state.tree == ($past(sw.state.tree) | $past(cmd_reg[11:8])))
      else $error("tree close mapping wrong");

   a_mask_keep: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
      sw.apply_close && !clear_now && !cmd_reg[`FMB_MSK_BANK_A] |=> $stable(sw.state.bank_a))
      else $error("unmasked bank changed");

   a_relay_stays: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
      sw.state.relay && !clear_now && !wr_rly_open |=> sw.state.relay)
      else $error("relays dropped open");

   a_bank_b_close: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
      sw.apply_close && !clear_now && cmd_reg[`FMB_MSK_BANK_B] && cmd_reg[7:4] <= 4'h9
      |=> sw.state.bank_b == $past(cmd_reg[7:4]))
      else $error("bank B close code not taken");

   a_open_tree: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
      wr_open && bp_wdata[`FMB_MSK_TREE]
      |=> sw.state.tree == ($past(sw.state.tree) & ~$past(bp_wdata[11:8])))
      else $error("tree open mapping wrong");

   a_relay_close: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
      sw.relay_close && !clear_now |=> sw.state.relay)
      else $error("isolation relays did not close");

   a_open_keep: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
      wr_open && !bp_wdata[`FMB_MSK_BANK_B] |=> $stable(sw.state.bank_b))
      else $error("unmasked bank changed on open");

endmodule : fmb_backplane_ctrl

// ===== hdl/fmb_params.svh
`ifndef FMB_PARAMS_SVH
`define FMB_PARAMS_SVH

// Register numbers on the backplane
`define FMB_REG_IDENT 3'h0
`define FMB_REG_RESET 3'h0
`define FMB_REG_ACCESS 3'h1
`define FMB_REG_STATUS 3'h2
`define FMB_REG_OPEN 3'h3
`define FMB_REG_RLY_OPEN 3'h4
`define FMB_REG_RLY_CLOSE 3'h5
`define FMB_REG_CLOSE 3'h6

// Command word fields
`define FMB_MSK_RELAY 15
`define FMB_MSK_TREE 14
`define FMB_MSK_BANK_B 13
`define FMB_MSK_BANK_A 12
`define FMB_TREE_HI 11
`define FMB_TREE_LO 8
`define FMB_BANK_B_HI 7
`define FMB_BANK_B_LO 4
`define FMB_BANK_A_HI 3
`define FMB_BANK_A_LO 0

// Reset and fixed values
`define FMB_BANK_OPEN 4'hF
`define FMB_BANK_MAX 4'h9
`define FMB_TREE_OPEN 4'h0
`define FMB_ID_UPPER 8'hFF
`define FMB_TERM_NONE 3'h7
`define FMB_STAT_UNDEF 4'h0

// Timing
`define FMB_CLK_NS 4
`define FMB_STROBE_NS 40
`define FMB_STROBE_CYC ((`FMB_STROBE_NS + `FMB_CLK_NS - 1) / `FMB_CLK_NS)

`endif

// ===== hdl/fmb_pkg.sv
package fmb_pkg;

   // Sequencer states, one-hot
   typedef enum logic [3:0] {
      FMB_ST_IDLE = 4'h1,
      FMB_ST_OPEN = 4'h2,
      FMB_ST_WAIT = 4'h4,
      FMB_ST_CLOSE = 4'h8
   } fmb_state_t;

   // Switch state as held by the bank module
   typedef struct packed {
      logic relay;
      logic [3:0] tree;
      logic [3:0] bank_b;
      logic [3:0] bank_a;
   } fmb_sw_state_t;

   // Decimal channel code to one-hot channel drive; invalid codes drive none
   function automatic logic [9:0] fmb_onehot10(input logic [3:0] code);
      logic [9:0] res;
      res = 10'h000;
      for (int i = 0; i < 10; i++) begin
         res[i] = (code == 4'(i));
      end
      return res;
   endfunction : fmb_onehot10

endpackage : fmb_pkg

// ===== hdl/fmb_sw_if.sv
`timescale 1ns/10ps
interface fmb_sw_if;
   logic clk_en;
   logic [15:0] cmd;
   logic clear_all;
   logic apply_open;
   logic apply_close;
   logic relay_open;
   logic relay_close;
   fmb_pkg::fmb_sw_state_t state;

   modport ctrl (output clk_en, output cmd, output clear_all, output apply_open, output apply_close,
      output relay_open, output relay_close, input state);
   modport bank (input clk_en, input cmd, input clear_all, input apply_open, input apply_close,
      input relay_open, input relay_close, output state);
endinterface : fmb_sw_if

// ===== hdl/fmb_switch_bank.sv
`timescale 1ns/10ps
`include "fmb_params.svh"
module fmb_switch_bank (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Command side
   fmb_sw_if.bank sw
);
   import fmb_pkg::*;

   logic relay_reg;
   logic [3:0] tree_reg;
   logic [3:0] bank_b_reg;
   logic [3:0] bank_a_reg;
   logic [3:0] nb;
   logic [3:0] na;

   assign nb = sw.cmd[`FMB_BANK_B_HI:`FMB_BANK_B_LO];
   assign na = sw.cmd[`FMB_BANK_A_HI:`FMB_BANK_A_LO];
   // Separate registers so each process owns its own variable
   assign sw.state = {relay_reg, tree_reg, bank_b_reg, bank_a_reg};

   // FET switch groups; masked-off groups hold
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tree_reg <= `FMB_TREE_OPEN;
         bank_b_reg <= `FMB_BANK_OPEN;
         bank_a_reg <= `FMB_BANK_OPEN;
      end else if (sw.clk_en) begin
         if (sw.clear_all) begin
            tree_reg <= `FMB_TREE_OPEN;
            bank_b_reg <= `FMB_BANK_OPEN;
            bank_a_reg <= `FMB_BANK_OPEN;
         end else if (sw.apply_open) begin
            if (sw.cmd[`FMB_MSK_TREE]) begin
               tree_reg <= tree_reg & ~sw.cmd[`FMB_TREE_HI:`FMB_TREE_LO];
            end
            if (sw.cmd[`FMB_MSK_BANK_B] && (nb == `FMB_BANK_OPEN || nb == bank_b_reg)) begin
               bank_b_reg <= `FMB_BANK_OPEN;
            end
            if (sw.cmd[`FMB_MSK_BANK_A] && (na == `FMB_BANK_OPEN || na == bank_a_reg)) begin
               bank_a_reg <= `FMB_BANK_OPEN;
            end
         end else if (sw.apply_close) begin
            if (sw.cmd[`FMB_MSK_TREE]) begin
               tree_reg <= tree_reg | sw.cmd[`FMB_TREE_HI:`FMB_TREE_LO];
            end
            if (sw.cmd[`FMB_MSK_BANK_B] && (nb <= `FMB_BANK_MAX || nb == `FMB_BANK_OPEN)) begin
               bank_b_reg <= nb;
            end
            if (sw.cmd[`FMB_MSK_BANK_A] && (na <= `FMB_BANK_MAX || na == `FMB_BANK_OPEN)) begin
               bank_a_reg <= na;
            end
         end
      end
   end

   // Isolation relays latch closed until opened or reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         relay_reg <= 1'b0;
      end else if (sw.clk_en) begin
         if (sw.clear_all || sw.relay_open) begin
            relay_reg <= 1'b0;
         end else if (sw.relay_close) begin
            relay_reg <= 1'b1;
         end
      end
   end

endmodule : fmb_switch_bank

// ===== dv/fmb_ctrl_model.sv
`timescale 1ns/10ps
module fmb_ctrl_model #(
   parameter int HOLD_CYC = 3
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Strobes from the card
   input wire logic bp_opening_pulse,
   input wire logic bp_closing_pulse,
   // Another card still breaking
   input wire logic other_opening,
   // Backplane view and pulse counts
   output logic bp_opening_in,
   output int open_cnt,
   output int close_cnt
);
   int hold_reg;
   logic open_dly_reg;
   logic close_dly_reg;
   int open_cnt_reg;
   int close_cnt_reg;

   // Wired line settles slowly after the card lets go
   always_ff @(posedge core_clk) begin
      if (rst) begin
         hold_reg <= 0;
      end else if (bp_opening_pulse) begin
         hold_reg <= HOLD_CYC;
      end else if (hold_reg != 0) begin
         hold_reg <= hold_reg - 1;
      end
   end

   // Opening line seen by every card, so makes wait for all breaks
   assign bp_opening_in = bp_opening_pulse | other_opening | (hold_reg != 0);

   // Count rising edges of each strobe
   always_ff @(posedge core_clk) begin
      if (rst) begin
         open_dly_reg <= 1'b0;
         close_dly_reg <= 1'b0;
         open_cnt_reg <= 0;
         close_cnt_reg <= 0;
      end else begin
         open_dly_reg <= bp_opening_pulse;
         close_dly_reg <= bp_closing_pulse;
         open_cnt_reg <= open_cnt_reg + int'(bp_opening_pulse & ~open_dly_reg);
         close_cnt_reg <= close_cnt_reg + int'(bp_closing_pulse & ~close_dly_reg);
      end
   end

   // Counts to the bench
   assign open_cnt = open_cnt_reg;
   assign close_cnt = close_cnt_reg;
endmodule : fmb_ctrl_model

// ===== dv/tb.sv
`timescale 1ns/10ps
module tb;
   import fmb_pkg::*;
   localparam int STROBE = 2;
   localparam logic [4:0] COMP_ID = 5'h0A; // Arbitrary value
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] bp_addr = 3'h0;
   logic bp_rd_stb = 1'b0;
   logic bp_wr_stb = 1'b0;
   logic [15:0] bp_wdata = 16'h0000;
   logic bp_sys_reset = 1'b0;
   logic term_present = 1'b0;
   logic [2:0] term_type = 3'h0;
   logic other_opening = 1'b0;
   logic [15:0] bp_rdata;
   logic bp_rdata_vld;
   logic bp_opening_in;
   logic bp_opening_pulse;
   logic bp_closing_pulse;
   logic relay_closed;
   logic [3:0] tree_closed;
   logic [9:0] bank_a_closed;
   logic [9:0] bank_b_closed;
   int open_cnt;
   int close_cnt;
   int error_cnt = 0;
   int compares = 0;
   logic [15:0] v;
   int n;

   // Clock
   always #2 core_clk = ~core_clk;

   // Design
   fmb_backplane_ctrl #(.COMPONENT_ID(COMP_ID), .STROBE_CYC(STROBE)) uut (
      .core_clk(core_clk), .rst(rst), .clk_en(1'b1), .bp_addr(bp_addr), .bp_rd_stb(bp_rd_stb),
      .bp_wr_stb(bp_wr_stb), .bp_wdata(bp_wdata), .bp_rdata(bp_rdata), .bp_rdata_vld(bp_rdata_vld),
      .bp_sys_reset(bp_sys_reset), .bp_opening_in(bp_opening_in), .bp_opening_pulse(bp_opening_pulse),
      .bp_closing_pulse(bp_closing_pulse), .term_present(term_present), .term_type(term_type),
      .relay_closed(relay_closed), .tree_closed(tree_closed), .bank_a_closed(bank_a_closed),
      .bank_b_closed(bank_b_closed));

   // Local controller
   fmb_ctrl_model model (
      .core_clk(core_clk), .rst(rst), .bp_opening_pulse(bp_opening_pulse),
      .bp_closing_pulse(bp_closing_pulse), .other_opening(other_opening),
      .bp_opening_in(bp_opening_in), .open_cnt(open_cnt), .close_cnt(close_cnt));

   // Compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One write cycle
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge core_clk);
      #1;
      bp_addr = a;
      bp_wdata = d;
      bp_wr_stb = 1'b1;
      @(posedge core_clk);
      #1;
      bp_wr_stb = 1'b0;
   endtask : wr

   // One read cycle, bounded wait for the answer
   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      int k;
      @(posedge core_clk);
      #1;
      bp_addr = a;
      bp_rd_stb = 1'b1;
      @(posedge core_clk);
      #1;
      bp_rd_stb = 1'b0;
      k = 0;
      while (bp_rdata_vld !== 1'b1 && k < 4) begin
         @(posedge core_clk);
         #1;
         k++;
      end
      chk({15'h0000, bp_rdata_vld}, 16'h0001);
      d = bp_rdata;
   endtask : rd

   // Poll the busy flag until the sequencer is idle
   task automatic wait_idle;
      logic [15:0] s;
      int k;
      s = 16'hFFFF;
      for (k = 0; k < 40 && s[0] !== 1'b0; k++) begin
         rd(3'h1, s);
      end
      chk({15'h0000, s[0]}, 16'h0000);
   endtask : wait_idle

   // Write then let the strobe finish
   task automatic cmd(input logic [2:0] a, input logic [15:0] d);
      wr(a, d);
      wait_idle();
   endtask : cmd

   // Status word and switch drives against expected codes
   task automatic chk_sw(input logic [3:0] t, input logic [3:0] b, input logic [3:0] a);
      logic [15:0] s;
      rd(3'h2, s);
      chk({4'h0, s[11:0]}, {4'h0, t, b, a});
      chk({6'h00, bank_a_closed}, (a < 4'hA) ? (16'h0001 << a) : 16'h0000);
      chk({6'h00, bank_b_closed}, (b < 4'hA) ? (16'h0001 << b) : 16'h0000);
      chk({12'h000, tree_closed}, {12'h000, t});
   endtask : chk_sw

   // Counts and verdict
   task automatic print_verdict;
      $display("Compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict

   // Watchdog
   initial begin
      #100000;
      error_cnt++;
      $display("Watchdog expired at t=%0t", $time);
      print_verdict();
   end

   // Main sequence
   initial begin
      repeat (16) @(posedge core_clk);
      #1;
      rst = 1'b0;
      chk_sw(4'h0, 4'hF, 4'hF);
      // Identity without and with a terminal module
      rd(3'h0, v);
      chk(v, {8'hFF, COMP_ID, 3'h7});
      term_present = 1'b1;
      term_type = 3'h2;
      rd(3'h0, v);
      chk(v, {8'hFF, COMP_ID, 3'h2});
      // Every decimal code in both banks
      for (n = 0; n < 10; n++) begin
         cmd(3'h6, {8'h30, 4'(9 - n), 4'(n)});
         chk_sw(4'h0, 4'(9 - n), 4'(n));
      end
      chk(16'(close_cnt), 16'h000A);
      // Tree only, bank data ignored
      cmd(3'h6, 16'h4A12);
      chk_sw(4'hA, 4'h0, 4'h9);
      // Open ch94 and bank A, bank B unmasked
      cmd(3'h3, 16'h583F);
      chk_sw(4'h2, 4'h0, 4'hF);
      chk(16'(open_cnt), 16'h0001);
      // Isolation relays
      cmd(3'h6, 16'h8000);
      chk({15'h0000, relay_closed}, 16'h0001);
      cmd(3'h3, 16'hFFFF);
      chk_sw(4'h0, 4'hF, 4'hF);
      chk({15'h0000, relay_closed}, 16'h0001);
      cmd(3'h4, 16'h1234);
      chk({15'h0000, relay_closed}, 16'h0000);
      chk(16'(open_cnt), 16'h0003);
      // Closing held off while the line shows opening
      other_opening = 1'b1;
      wr(3'h5, 16'h0000);
      repeat (8) @(posedge core_clk);
      #1;
      chk({15'h0000, relay_closed}, 16'h0000);
      other_opening = 1'b0;
      wait_idle();
      chk({15'h0000, relay_closed}, 16'h0001);
      chk(16'(close_cnt), 16'h000D);
      // Reset write cancels a pending close and opens all
      other_opening = 1'b1;
      wr(3'h6, 16'hF123);
      wr(3'h0, 16'h0000);
      other_opening = 1'b0;
      wait_idle();
      chk_sw(4'h0, 4'hF, 4'hF);
      chk({15'h0000, relay_closed}, 16'h0000);
      chk(16'(close_cnt), 16'h000D);
      // Backplane reset opens all switches and relays
      cmd(3'h6, 16'hF123);
      chk_sw(4'h1, 4'h2, 4'h3);
      @(posedge core_clk);
      #1;
      bp_sys_reset = 1'b1;
      @(posedge core_clk);
      #1;
      bp_sys_reset = 1'b0;
      wait_idle();
      chk_sw(4'h0, 4'hF, 4'hF);
      chk({15'h0000, relay_closed}, 16'h0000);
      print_verdict();
   end
endmodule : tb
